// ===== design/timer_pkg.sv
// constants, field layouts and carrier types of the auto-reload timer
// assumes one system clock domain; the register port is a plain byte-wide special-function port
// What this block does
// [R1] auto-reload uses reload bytes for count bytes
// [R2] capture mode: reload bytes hold captured counts
// [R3] unsplit: count bytes form one 16-bit counter
// [R4] split: each count byte is its own timer
// [R5] high flag set on high byte rollover
// [R6] unsplit: high flag set on 16-bit wrap
// [R7] enabled high flag raises interrupt request
// [R8] flags cleared only by software control writes
// [R9] low flag set on every low rollover
// [R10] low enable plus timer enable: low interrupt
// [R11] capture edge copies count and requests interrupt
// [R12] split bit picks 16-bit or two 8-bit
// [R13] run bit gates counting; split low always runs
// [R14] software writes reserved bit one as zero
// [R15] clock select: system/12 or external/8
// [R16] capture taken on capture pin falling edge
// [R17] outside capture mode, overflow loads reload value same cycle
// [R18] external clock synchronized, one step per eight rising edges
package timer_pkg;

  // register addresses on the special-function port
  localparam logic [7:0] CONTROL_ADDR = 8'h91;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;

  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // byte limits
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // clock dividers: system clock by twelve, external clock by eight
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] SYS_DIV_ONE = 4'h1;
  localparam logic [3:0] SYS_DIV_RESET = 4'h0;
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
  localparam logic [2:0] EXT_DIV_ONE = 3'h1;
  localparam logic [2:0] EXT_DIV_RESET = 3'h0;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // control byte layout, bit 7 first
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_overflow_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic reserved;
    logic external_clock_select;
  } control_t;

  // one access on the special-function port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

endpackage

// ===== design/autoreload_split_capture_timer.sv
// auto-reload timer: 16-bit or split 8-bit, with capture into the reload bytes
// assumes requests, clock enable and interrupt enable come from logic on sys_clk;
// the external clock and capture source are asynchronous pins
`timescale 1ns/1ps
module autoreload_split_capture_timer (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // special-function register port
  input wire timer_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // interrupt controller side
  input wire logic timer_irq_enable,
  output logic irq_request,
  // asynchronous pins
  input wire logic ext_clk_pin,
  input wire logic capture_pin
);
  import timer_pkg::*;

  // register state
  control_t ctrl; // control byte
  control_t next_ctrl;
  logic [7:0] reload_lo; // timer_a_reload_low
  logic [7:0] next_reload_lo;
  logic [7:0] reload_hi; // timer_a_reload_high
  logic [7:0] next_reload_hi;
  logic [7:0] count_lo; // timer_a_count_low
  logic [7:0] next_count_lo;
  logic [7:0] count_hi; // timer_a_count_high
  logic [7:0] next_count_hi;
  logic [7:0] next_rdata;
  logic next_irq;

  // clocking state
  logic [3:0] sys_div; // system clock prescaler
  logic [3:0] next_sys_div;
  logic [2:0] ext_div; // external edge divider
  logic [2:0] next_ext_div;
  logic [2:0] ext_sync; // [0] first stage, [1] second, [2] edge history
  logic [2:0] cap_sync;

  // decoded strobes
  logic wr_ctrl, wr_rl, wr_rh, wr_cl, wr_ch;
  logic tick_sys, ext_rise, tick_ext, tick;
  logic cap_fall;
  logic step_lo, step_hi, lo_ovf, hi_ovf;
  logic [7:0] wrap_lo, wrap_hi;

  // address decode of writes
  always_comb begin
    wr_ctrl = sfr_req.wr && (sfr_req.addr == CONTROL_ADDR);
    wr_rl = sfr_req.wr && (sfr_req.addr == RELOAD_LOW_ADDR);
    wr_rh = sfr_req.wr && (sfr_req.addr == RELOAD_HIGH_ADDR);
    wr_cl = sfr_req.wr && (sfr_req.addr == COUNT_LOW_ADDR);
    wr_ch = sfr_req.wr && (sfr_req.addr == COUNT_HIGH_ADDR);
  end

  // clock source selection and edge detection
  always_comb begin
    tick_sys = (sys_div == SYS_DIV_LAST); // [R15]
    // only the second and third stages are looked at, never the first
    ext_rise = ext_sync[1] && !ext_sync[2]; // [R18]
    tick_ext = ext_rise && (ext_div == EXT_DIV_LAST); // [R18]
    tick = ctrl.external_clock_select ? tick_ext : tick_sys; // [R15]
    // a falling-edge detector on the synchronised capture pin [R16]
    cap_fall = !cap_sync[1] && cap_sync[2];
    next_sys_div = tick_sys ? SYS_DIV_RESET : sys_div + SYS_DIV_ONE;
    next_ext_div = ext_rise ? ext_div + EXT_DIV_ONE : ext_div;
  end

  // step and overflow decode
  always_comb begin
    // split low byte ignores the run bit
    step_lo = tick && (ctrl.split_mode_select || ctrl.run_control); // [R13] [R12]
    // unsplit high byte only steps on a low carry
    step_hi = tick && ctrl.run_control && (ctrl.split_mode_select || count_lo == BYTE_MAX); // [R3] [R4]
    lo_ovf = step_lo && (count_lo == BYTE_MAX); // [R9]
    hi_ovf = step_hi && (count_hi == BYTE_MAX); // [R5] [R6]
    // capture mode has no reload value, so bytes wrap to zero
    wrap_hi = ctrl.capture_enable ? BYTE_ZERO : reload_hi; // [R1] [R17]
    if (ctrl.capture_enable) begin
      wrap_lo = BYTE_ZERO;
    end else if (ctrl.split_mode_select || hi_ovf) begin
      wrap_lo = reload_lo; // [R1] [R17]
    end else begin
      wrap_lo = BYTE_ZERO; // plain carry into the high byte
    end
  end

  // next values of the registers
  always_comb begin
    next_count_lo = count_lo;
    next_count_hi = count_hi;
    next_reload_lo = reload_lo;
    next_reload_hi = reload_hi;
    next_ctrl = ctrl;
    // counting
    if (lo_ovf) begin
      next_count_lo = wrap_lo; // [R17]
    end else if (step_lo) begin
      next_count_lo = count_lo + BYTE_ONE; // [R3] [R4]
    end
    if (hi_ovf) begin
      next_count_hi = wrap_hi; // [R17]
    end else if (step_hi) begin
      next_count_hi = count_hi + BYTE_ONE;
    end
    // software writes to count bytes win over a step
    if (wr_cl) begin
      next_count_lo = sfr_req.wdata;
    end
    if (wr_ch) begin
      next_count_hi = sfr_req.wdata;
    end
    if (wr_rl) begin
      next_reload_lo = sfr_req.wdata;
    end
    if (wr_rh) begin
      next_reload_hi = sfr_req.wdata;
    end
    // capture wins over a reload write in the same cycle
    if (ctrl.capture_enable && cap_fall) begin
      next_reload_lo = count_lo; // [R2] [R11]
      next_reload_hi = count_hi; // [R2] [R11]
    end
    // control write; flags clear only here
    if (wr_ctrl) begin
      next_ctrl = control_t'(sfr_req.wdata); // [R8]
      next_ctrl.reserved = 1'b0; // reads zero whatever is written [R14]
    end
    // hardware sets win over a software clear
    if (hi_ovf || (ctrl.capture_enable && cap_fall)) begin
      next_ctrl.high_overflow_flag = 1'b1; // [R5] [R6] [R11]
    end
    if (lo_ovf) begin
      next_ctrl.low_overflow_flag = 1'b1; // [R9]
    end
  end

  // read data and interrupt request
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        CONTROL_ADDR: next_rdata = ctrl;
        RELOAD_LOW_ADDR: next_rdata = reload_lo;
        RELOAD_HIGH_ADDR: next_rdata = reload_hi;
        COUNT_LOW_ADDR: next_rdata = count_lo;
        COUNT_HIGH_ADDR: next_rdata = count_hi;
        default: next_rdata = READ_UNMAPPED;
      endcase
    end
    // level request, drops once software clears the flags
    next_irq = timer_irq_enable && (ctrl.high_overflow_flag ||
      (ctrl.low_overflow_flag && ctrl.low_overflow_irq_enable)); // [R7] [R10]
  end

  // state registers, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= control_t'(CONTROL_RESET);
      reload_lo <= BYTE_RESET;
      reload_hi <= BYTE_RESET;
      count_lo <= BYTE_RESET;
      count_hi <= BYTE_RESET;
      sfr_rdata <= BYTE_RESET;
      irq_request <= 1'b0;
      sys_div <= SYS_DIV_RESET;
      ext_div <= EXT_DIV_RESET;
      ext_sync <= SYNC_RESET;
      cap_sync <= SYNC_RESET;
    end else if (ce) begin
      ctrl <= next_ctrl;
      reload_lo <= next_reload_lo;
      reload_hi <= next_reload_hi;
      count_lo <= next_count_lo;
      count_hi <= next_count_hi;
      sfr_rdata <= next_rdata;
      irq_request <= next_irq;
      sys_div <= next_sys_div;
      ext_div <= next_ext_div;
      ext_sync <= {ext_sync[1:0], ext_clk_pin}; // [R18]
      cap_sync <= {cap_sync[1:0], capture_pin};
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_split_low_reload: assert property ( // [R1]
    ce && tick && ctrl.split_mode_select && !ctrl.capture_enable && count_lo == BYTE_MAX && !wr_cl
    |=> count_lo == $past(reload_lo))
    else $error("split low byte did not reload");

  chk_capture_copy: assert property ( // [R2]
    ce && ctrl.capture_enable && cap_fall
    |=> {reload_hi, reload_lo} == $past({count_hi, count_lo}) && ctrl.high_overflow_flag)
    else $error("capture did not copy count");

  chk_sixteen_carry: assert property ( // [R3]
    ce && tick && ctrl.run_control && !ctrl.split_mode_select && count_lo == BYTE_MAX
    && count_hi != BYTE_MAX && !wr_cl && !wr_ch
    |=> count_hi == $past(count_hi) + BYTE_ONE && count_lo == BYTE_ZERO)
    else $error("16-bit carry wrong");

  chk_split_low_runs: assert property ( // [R4]
    ce && tick && ctrl.split_mode_select && !ctrl.run_control && count_lo != BYTE_MAX
    && !wr_cl && !wr_ch
    |=> count_lo == $past(count_lo) + BYTE_ONE && count_hi == $past(count_hi))
    else $error("split bytes not independent");

  chk_high_flag_set: assert property ( // [R5]
    ce && hi_ovf |=> ctrl.high_overflow_flag)
    else $error("high flag missed");

  chk_low_flag_set: assert property ( // [R9]
    ce && lo_ovf |=> ctrl.low_overflow_flag)
    else $error("low flag missed");

  chk_flag_sticky: assert property ( // [R8]
    ctrl.high_overflow_flag && !(ce && wr_ctrl) |=> ctrl.high_overflow_flag)
    else $error("high flag cleared by hardware");

  // request is registered from this cycle's flag, so it must show one cycle later
  chk_irq_follows: assert property ( // [R7]
    ce && timer_irq_enable && ctrl.high_overflow_flag |=> irq_request)
    else $error("no interrupt request");

  chk_run_gates_high: assert property ( // [R13]
    ce && !ctrl.run_control && !wr_ch |=> count_hi == $past(count_hi))
    else $error("high byte counted while stopped");

  chk_sys_divide: assert property ( // [R15]
    ce && tick_sys |=> !tick_sys)
    else $error("system divider too fast");

  cov_sixteen_wrap: cover property (ce && hi_ovf && !ctrl.split_mode_select);
  cov_split_low_wrap: cover property (ce && lo_ovf && ctrl.split_mode_select);
  cov_capture: cover property (ce && ctrl.capture_enable && cap_fall);

endmodule

// ===== test/autoreload_split_capture_timer_tb.sv
// self-checking bench for the auto-reload split/capture timer
// assumes timer_pkg and the timer top are compiled first; one 100 MHz clock
`timescale 1ns/1ps
module autoreload_split_capture_timer_tb;
  import timer_pkg::*;
  // one expected read result, chk low for polls
  typedef struct {logic [7:0] v; bit chk;} note_t;
  logic sys_clk, rst, ce, timer_irq_enable, irq_request, ext_clk_pin, capture_pin;
  sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, got;
  logic taken; // a read was taken at the last edge
  note_t notes[$], nt;
  int miscompares, n_checks;
  logic [31:0] seed = 32'hceebba5a;
  logic [7:0] vals[5];
  logic [7:0] addrs[6] = '{CONTROL_ADDR, RELOAD_LOW_ADDR, RELOAD_HIGH_ADDR, COUNT_LOW_ADDR, COUNT_HIGH_ADDR, 8'h92};

  autoreload_split_capture_timer autoreload_split_capture_timer_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .irq_request(irq_request),
    .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin));

  // next pseudo-random word
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one write strobe, launched at the falling edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge sys_clk);
    sfr_req.wr = 1'b0;
  endtask

  // one read strobe; the note is queued, the value kept for polling
  task automatic rd(logic [7:0] a, logic [7:0] e, bit c);
    @(negedge sys_clk);
    sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    notes.push_back('{e, c});
    @(negedge sys_clk);
    sfr_req.rd = 1'b0;
    got = sfr_rdata;
  endtask

  // read control until a masked bit shows; bounded so a dead timer ends the run
  task automatic poll(logic [7:0] m);
    for (int i = 0; i < 40; i++) begin
      rd(CONTROL_ADDR, 8'h00, 1'b0);
      if ((got & m) != 8'h00) return;
    end
    miscompares++;
    stop_test();
  endtask

  task automatic chk_irq(logic e);
    check({7'h00, irq_request}, {7'h00, e});
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // note which edges took a read
  always @(posedge sys_clk) taken <= sfr_req.rd & ce & ~rst;

  // results settle by the falling edge; take the oldest note
  always @(negedge sys_clk) begin
    if (taken && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.chk) check(sfr_rdata, nt.v); // tags stand where the notes are queued
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    timer_irq_enable = 1'b1;
    ext_clk_pin = 1'b0;
    capture_pin = 1'b1;
    sfr_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    miscompares = 0;
    n_checks = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    // reset values, unmapped address reads zero
    foreach (addrs[i]) rd(addrs[i], 8'h00, 1'b1);
    // random bytes stored; a stopped timer keeps them
    for (int i = 1; i < 5; i++) begin
      seed = lfsr(seed);
      vals[i] = seed[7:0] & 8'h7f; // kept low so no byte wraps in a short run
      wr(addrs[i], vals[i]);
    end
    repeat (30) @(negedge sys_clk);
    for (int i = 1; i < 5; i++) rd(addrs[i], vals[i], 1'b1);
    wr(CONTROL_ADDR, 8'h38);
    rd(CONTROL_ADDR, 8'h38, 1'b1);
    // writes while frozen are ignored
    ce = 1'b0;
    wr(RELOAD_LOW_ADDR, ~vals[1]);
    ce = 1'b1;
    rd(RELOAD_LOW_ADDR, vals[1], 1'b1);
    // 16-bit wrap reloads both bytes, sets both flags
    // stop the split low byte first so it cannot wrap before the run starts
    wr(CONTROL_ADDR, 8'h00);
    wr(COUNT_LOW_ADDR, 8'hff);
    wr(COUNT_HIGH_ADDR, 8'hff);
    wr(CONTROL_ADDR, 8'h04);
    poll(8'h80);
    rd(COUNT_LOW_ADDR, vals[1], 1'b1);
    rd(COUNT_HIGH_ADDR, vals[2], 1'b1);
    rd(CONTROL_ADDR, 8'hc4, 1'b1);
    chk_irq(1'b1);
    timer_irq_enable = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_irq(1'b0);
    timer_irq_enable = 1'b1;
    wr(CONTROL_ADDR, 8'h00);
    rd(CONTROL_ADDR, 8'h00, 1'b1);
    chk_irq(1'b0);
    // split: low byte runs alone, high byte waits for run
    wr(COUNT_LOW_ADDR, 8'hff);
    wr(COUNT_HIGH_ADDR, 8'hff);
    wr(CONTROL_ADDR, 8'h08);
    poll(8'h40);
    rd(COUNT_LOW_ADDR, vals[1], 1'b1);
    chk_irq(1'b0);
    rd(COUNT_HIGH_ADDR, 8'hff, 1'b1);
    wr(CONTROL_ADDR, 8'h6c);
    @(negedge sys_clk);
    chk_irq(1'b1);
    poll(8'h80);
    rd(COUNT_HIGH_ADDR, vals[2], 1'b1);
    // capture copies the count into the reload bytes
    wr(CONTROL_ADDR, 8'h10);
    seed = lfsr(seed);
    wr(COUNT_LOW_ADDR, seed[7:0]);
    wr(COUNT_HIGH_ADDR, seed[15:8]);
    capture_pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    rd(RELOAD_LOW_ADDR, seed[7:0], 1'b1);
    rd(RELOAD_HIGH_ADDR, seed[15:8], 1'b1);
    rd(CONTROL_ADDR, 8'h90, 1'b1);
    chk_irq(1'b1);
    // external clock: one step per eight synchronised edges
    wr(CONTROL_ADDR, 8'h05);
    wr(COUNT_LOW_ADDR, 8'h00);
    for (int i = 1; i <= 8; i++) begin
      ext_clk_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      ext_clk_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
      if (i == 7) rd(COUNT_LOW_ADDR, 8'h00, 1'b1);
    end
    rd(COUNT_LOW_ADDR, 8'h01, 1'b1);
    repeat (2) @(negedge sys_clk);
    stop_test();
  end
endmodule
